// file: src/qrbs_regs.vh
// Constants for the burst SRAM model: widths, counts and reset values.
// Assumes it is included by bare name from src/ before any module that uses it.
// How it works
// - Read data follows start by 1.5 cycles with DLL on, 1 cycle with it off.
// - Every access moves four 18-bit words over two clock cycles.
// - Read select low at K rise starts a read and latches the address.
// - After the next K rise words leave on alternating output clock edges.
// - A read request on the K rise right after a read start is ignored.
// - Deselected read port finishes bursts, then floats after next positive output edge.
// - Write select low at K rise starts a write; four words commit together.
// - A write request on the K rise right after a write start is ignored.
// - Deselected write port finishes its burst, then ignores write inputs.
// - Active-low byte selects travel with every word; high keeps stored byte.
// - Both output clocks high just after reset release select single clock mode, fixed until the next reset.
// - Reads see the newest data, including writes still in flight.
// - Both selects together: read unless a read started last.
// - Selects sampled only at K rise; a read start blocks a write start on the same rise; bursts always finish.
// - Selects and byte selects are registered on input clock rising edges.
// - Two free-running echo clocks follow the output clocks, or K in single mode.
// - Output impedance is readjusted once every 1024 input clock cycles.
// - Burst words use the latched address then the next three addresses.
// - After reset both ports are idle and the read outputs float.
`ifndef QRBS_REGS_VH
`define QRBS_REGS_VH
`define QRBS_WORD_W 18
`define QRBS_BYTE_W 9
`define QRBS_BURST 4
`define QRBS_MASK_W 2
`define QRBS_IMP_PERIOD 1024
`define QRBS_IMP_LAST 10'h3FF
`define QRBS_STRAP_WAIT 2'h3
`define QRBS_Q_RST 18'h00000
`define QRBS_FIFO_DEPTH 8
`endif

// file: src/qrbs_fifo.v
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset shared with its user.
`timescale 1ns/1ps
`default_nettype none
module qrbs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8
)(
	input wire i_clk,
	input wire i_reset,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	function integer qrbs_clog2;
		input integer n;
		integer v;
		begin
			v = n - 1;
			qrbs_clog2 = 1;
			while (v > 1)
			begin
				v = v >> 1;
				qrbs_clog2 = qrbs_clog2 + 1;
			end
		end
	endfunction
	localparam integer PW = qrbs_clog2(DEPTH);
	localparam integer LAST_I = DEPTH - 1;
	localparam integer FULL_I = DEPTH;
	localparam [PW-1:0] LAST = LAST_I[PW-1:0];
	localparam [PW:0] FULL = FULL_I[PW:0];
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [PW-1:0] wr_ptr;
	reg [PW-1:0] rd_ptr;
	reg [PW:0] count;
	wire push = i_in_valid & o_in_ready;
	wire pop = o_out_valid & i_out_ready;
	assign o_in_ready = (count != FULL);
	assign o_out_valid = (count != {(PW+1){1'b0}});
	assign o_out_data = store[rd_ptr];
	always @(posedge i_clk)
	begin
		if (push)
			store[wr_ptr] <= i_in_data;
	end
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_ptr <= {PW{1'b0}};
			rd_ptr <= {PW{1'b0}};
			count <= {(PW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == LAST) ? {PW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == LAST) ? {PW{1'b0}} : rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: src/qrbs_sram.v
// Burst SRAM with separate read and write ports sharing one address bus.
// Assumes the link clocks and pins are slow against i_clk, so every pin is
// sampled through two flip-flops and link clock edges are found by comparison.
`timescale 1ns/1ps
`default_nettype none
`include "qrbs_regs.vh"
module qrbs_sram #(
	parameter AW = 4,
	parameter FIFO_DEPTH = `QRBS_FIFO_DEPTH
)(
	input wire i_clk,
	input wire i_reset,
	input wire i_k,
	input wire i_k_n,
	input wire i_c,
	input wire i_c_n,
	input wire [AW-1:0] i_addr,
	input wire i_read_port_select_n,
	input wire i_write_port_select_n,
	input wire [1:0] i_byte_write_select_n,
	input wire [`QRBS_WORD_W-1:0] i_data,
	input wire i_dll_disable_n,
	output reg [`QRBS_WORD_W-1:0] o_q,
	output reg o_q_oe,
	output reg o_echo_timing_pos,
	output reg o_echo_timing_neg,
	output reg o_impedance_update
);
	localparam W = `QRBS_WORD_W;
	localparam BW = `QRBS_BYTE_W;
	localparam NB = `QRBS_BURST;
	localparam MW = `QRBS_MASK_W;
	localparam SW = AW + 27;
	localparam FW = AW + NB * W + NB * MW;

	// Byte merge: a low select bit lets the new byte replace the stored one.
	function [W-1:0] merge;
		input [W-1:0] old;
		input [W-1:0] nw;
		input [MW-1:0] m;
		begin
			merge = old;
			if (!m[0])
				merge[BW-1:0] = nw[BW-1:0];
			if (!m[1])
				merge[W-1:BW] = nw[W-1:BW];
		end
	endfunction

	// Overlay of a burst's valid words onto a word read at address x.
	function [W-1:0] fwd;
		input [W-1:0] cur;
		input [AW-1:0] x;
		input [AW-1:0] ba;
		input [NB*W-1:0] d;
		input [NB*MW-1:0] m;
		input [NB-1:0] v;
		integer i;
		begin
			fwd = cur;
			for (i = 0; i < NB; i = i + 1)
				if (v[i] && (ba + i[AW-1:0]) == x)
					fwd = merge(fwd, d[i*W +: W], m[i*MW +: MW]);
		end
	endfunction

	// Pin sampling; only the second stage and the edge history are read.
	wire [SW-1:0] raw = {i_k, i_k_n, i_c, i_c_n, i_dll_disable_n, i_read_port_select_n,
		i_write_port_select_n, i_byte_write_select_n, i_data, i_addr};
	reg [SW-1:0] sync1;
	reg [SW-1:0] sync2;
	reg [3:0] clk_prev;
	wire k_s = sync2[SW-1];
	wire kn_s = sync2[SW-2];
	wire c_s = sync2[SW-3];
	wire cn_s = sync2[SW-4];
	wire dll_on = sync2[SW-5];
	wire rd_sel_n = sync2[SW-6];
	wire wr_sel_n = sync2[SW-7];
	wire [MW-1:0] byte_sel_n = sync2[AW+W+MW-1:AW+W];
	wire [W-1:0] din = sync2[AW+W-1:AW];
	wire [AW-1:0] ain = sync2[AW-1:0];
	wire k_rise = k_s & ~clk_prev[3];
	wire kn_rise = kn_s & ~clk_prev[2];
	wire c_rise = c_s & ~clk_prev[1];
	wire cn_rise = cn_s & ~clk_prev[0];

	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sync1 <= {SW{1'b0}};
			sync2 <= {SW{1'b0}};
			clk_prev <= 4'h0;
		end
		else
		begin
			sync1 <= raw;
			sync2 <= sync1;
			clk_prev <= {k_s, kn_s, c_s, cn_s};
		end
	end

	// The strap is caught a few cycles after release, once the samplers hold real levels.
	reg [1:0] strap_cnt;
	reg strap_done;
	reg single;
	wire op_rise = single ? k_rise : c_rise;
	wire on_rise = single ? kn_rise : cn_rise;
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			strap_cnt <= 2'h0;
			strap_done <= 1'b0;
			single <= 1'b0;
			o_echo_timing_pos <= 1'b0;
			o_echo_timing_neg <= 1'b0;
		end
		else
		begin
			if (!strap_done)
			begin
				if (strap_cnt == `QRBS_STRAP_WAIT)
				begin
					single <= c_s & cn_s;
					strap_done <= 1'b1;
				end
				else
					strap_cnt <= strap_cnt + 2'h1;
			end
			o_echo_timing_pos <= single ? k_s : c_s;
			o_echo_timing_neg <= single ? kn_s : cn_s;
		end
	end

	// Impedance update pulse, one per period of input clock cycles.
	reg [9:0] imp_cnt;
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			imp_cnt <= 10'h000;
			o_impedance_update <= 1'b0;
		end
		else
		begin
			o_impedance_update <= k_rise & (imp_cnt == `QRBS_IMP_LAST);
			if (k_rise)
				imp_cnt <= imp_cnt + 10'h001;
		end
	end

	// Start arbitration at K rise; one start per rise on the shared address bus.
	reg rd_last;
	reg wr_last;
	wire start_rd = k_rise & ~rd_sel_n & ~rd_last;
	wire start_wr = k_rise & ~wr_sel_n & ~wr_last & ~start_rd;
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rd_last <= 1'b0;
			wr_last <= 1'b0;
		end
		else if (k_rise)
		begin
			rd_last <= start_rd;
			wr_last <= start_wr;
		end
	end

	// Storage and the write FIFO between capture and commit.
	reg [W-1:0] mem [0:(1<<AW)-1];
	wire f_in_ready;
	wire f_valid;
	wire [FW-1:0] f_head;
	wire [AW-1:0] f_addr = f_head[FW-1:FW-AW];
	wire [NB*W-1:0] f_data = f_head[NB*W+NB*MW-1:NB*MW];
	wire [NB*MW-1:0] f_mask = f_head[NB*MW-1:0];

	// Write capture.
	reg wr_act;
	reg wr_wait;
	reg [1:0] wr_idx;
	reg [AW-1:0] wr_addr;
	reg [NB*W-1:0] wr_data;
	reg [NB*MW-1:0] wr_mask;
	reg [NB-1:0] wr_got;
	reg wr_full;
	reg wn_v;
	reg wn_wait;
	reg [AW-1:0] wn_addr;
	wire wr_cap = wr_act & (~wr_wait | k_rise) & (wr_idx[0] ? kn_rise : k_rise);
	wire wr_free = ~wr_act & ~wr_full;

	// Read path.
	reg rd_act;
	reg rd_wait;
	reg [1:0] rd_idx;
	reg [AW-1:0] rd_addr;
	reg rn_v;
	reg rn_wait;
	reg [AW-1:0] rn_addr;
	reg q_off_pend;
	wire rd_pos_slot = (rd_idx[0] == dll_on);
	wire rd_emit = rd_act & (~rd_wait | k_rise) & (rd_pos_slot ? op_rise : on_rise);
	wire rd_done = rd_emit & (rd_idx == 2'h3);
	wire rd_free = ~rd_act | rd_done;
	wire [AW-1:0] rd_x = rd_addr + rd_idx;
	wire [W-1:0] rd_base = fwd(mem[rd_x], rd_x, f_addr, f_data, f_mask, {NB{f_valid}});
	wire [W-1:0] rd_word = fwd(rd_base, rd_x, wr_addr, wr_data, wr_mask, wr_got);

	// The array takes one access per cycle, so a commit waits while a read word is fetched.
	wire f_drain = f_valid & ~rd_emit;
	qrbs_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_in_valid(wr_full),
		.o_in_ready(f_in_ready),
		.i_in_data({wr_addr, wr_data, wr_mask}),
		.o_out_valid(f_valid),
		.i_out_ready(~rd_emit),
		.o_out_data(f_head)
	);

	always @(posedge i_clk)
	begin : commit
		integer i;
		if (f_drain)
			for (i = 0; i < NB; i = i + 1)
				mem[f_addr + i[AW-1:0]] <= merge(mem[f_addr + i[AW-1:0]],
					f_data[i*W +: W], f_mask[i*MW +: MW]);
	end

	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_act <= 1'b0;
			wr_wait <= 1'b0;
			wr_idx <= 2'h0;
			wr_addr <= {AW{1'b0}};
			wr_data <= {(NB*W){1'b0}};
			wr_mask <= {(NB*MW){1'b1}};
			wr_got <= {NB{1'b0}};
			wr_full <= 1'b0;
			wn_v <= 1'b0;
			wn_wait <= 1'b0;
			wn_addr <= {AW{1'b0}};
		end
		else
		begin
			if (k_rise)
			begin
				wr_wait <= 1'b0;
				wn_wait <= 1'b0;
			end
			// Words land only while a burst is open; otherwise the data pins are ignored.
			if (wr_cap)
			begin
				wr_data[wr_idx*W +: W] <= din;
				wr_mask[wr_idx*MW +: MW] <= byte_sel_n;
				wr_got[wr_idx] <= 1'b1;
				wr_idx <= wr_idx + 2'h1;
				if (wr_idx == 2'h3)
				begin
					wr_act <= 1'b0;
					wr_full <= 1'b1;
				end
			end
			// A full FIFO holds the burst here and stalls the next one.
			if (wr_full & f_in_ready)
			begin
				wr_full <= 1'b0;
				wr_got <= {NB{1'b0}};
			end
			if (start_wr & wr_free & ~wn_v)
			begin
				wr_act <= 1'b1;
				wr_wait <= 1'b1;
				wr_idx <= 2'h0;
				wr_addr <= ain;
			end
			else if (start_wr)
			begin
				wn_v <= 1'b1;
				wn_wait <= 1'b1;
				wn_addr <= ain;
			end
			else if (wn_v & wr_free)
			begin
				wr_act <= 1'b1;
				wr_wait <= wn_wait & ~k_rise;
				wr_idx <= 2'h0;
				wr_addr <= wn_addr;
				wn_v <= 1'b0;
			end
		end
	end

	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rd_act <= 1'b0;
			rd_wait <= 1'b0;
			rd_idx <= 2'h0;
			rd_addr <= {AW{1'b0}};
			rn_v <= 1'b0;
			rn_wait <= 1'b0;
			rn_addr <= {AW{1'b0}};
			q_off_pend <= 1'b0;
			o_q <= `QRBS_Q_RST;
			o_q_oe <= 1'b0;
		end
		else
		begin
			if (k_rise)
			begin
				rd_wait <= 1'b0;
				rn_wait <= 1'b0;
			end
			if (rd_emit)
			begin
				o_q <= rd_word;
				o_q_oe <= 1'b1;
				rd_idx <= rd_idx + 2'h1;
				q_off_pend <= 1'b0;
			end
			if (rd_done)
			begin
				rd_act <= 1'b0;
				if (~rn_v & ~start_rd)
					q_off_pend <= 1'b1;
			end
			// Outputs float one positive output edge after the last word.
			if (q_off_pend & op_rise & ~rd_emit)
			begin
				o_q_oe <= 1'b0;
				q_off_pend <= 1'b0;
			end
			if (start_rd | rn_v)
				q_off_pend <= 1'b0;
			if (start_rd & rd_free & ~rn_v)
			begin
				rd_act <= 1'b1;
				rd_wait <= 1'b1;
				rd_idx <= 2'h0;
				rd_addr <= ain;
			end
			else if (start_rd)
			begin
				rn_v <= 1'b1;
				rn_wait <= 1'b1;
				rn_addr <= ain;
			end
			else if (rn_v & rd_free)
			begin
				rd_act <= 1'b1;
				rd_wait <= rn_wait & ~k_rise;
				rd_idx <= 2'h0;
				rd_addr <= rn_addr;
				rn_v <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/qrbs_checker.sv
// Port checker for the burst SRAM, bound into its top module.
// Assumes i_clk runs much faster than the link clocks.
`timescale 1ns/1ps
`default_nettype none
module qrbs_checker (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_c,
	input wire logic i_c_n,
	input wire logic i_read_port_select_n,
	input wire logic [17:0] o_q,
	input wire logic o_q_oe,
	input wire logic o_echo_timing_pos,
	input wire logic o_echo_timing_neg,
	input wire logic o_impedance_update
);
	logic [7:0] since_rd;
	// It saturates, so an old read never looks recent again.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			since_rd <= 8'hFF;
		else if (!i_read_port_select_n)
			since_rd <= 8'h00;
		else if (since_rd != 8'hFF)
			since_rd <= since_rd + 8'h01;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// The first edge is skipped, as the reset branch has not yet run before it.
	reset_idle_a: assert property (disable iff (1'b0)
		i_reset && $past(i_reset) |-> !o_q_oe && !o_impedance_update)
		else $error("outputs active in reset");
	oe_cause_a: assert property ($rose(o_q_oe) |-> since_rd < 8'h18)
		else $error("read data without a read start");
	oe_float_a: assert property (o_q_oe |-> since_rd < 8'h30)
		else $error("read outputs not released");
	burst_len_a: assert property ($rose(o_q_oe) |-> o_q_oe [*8])
		else $error("read burst too short");
	word_rate_a: assert property ($changed(o_q) |=> $stable(o_q) [*2])
		else $error("read words too close");
	imp_pulse_a: assert property (o_impedance_update |=> !o_impedance_update [*8])
		else $error("impedance pulses too close");
	echo_pos_a: assert property ($rose(i_c) |-> ##[1:6] $rose(o_echo_timing_pos))
		else $error("positive echo clock lost");
	echo_neg_a: assert property ($rose(i_c_n) |-> ##[1:6] $rose(o_echo_timing_neg))
		else $error("negative echo clock lost");
	cover property ($rose(o_q_oe));
	cover property ($fell(o_q_oe));
	cover property (o_impedance_update);
endmodule
`default_nettype wire

// file: tb/qrbs_ctl.sv
// Memory controller model: link clocks, request pins and read capture.
// Assumes i_clk at eight times the link rate; pins move only at i_clk rises.
`timescale 1ns/1ps
`default_nettype none
module qrbs_ctl (
	input wire logic i_clk,
	input wire logic i_strap,
	input wire logic i_dll_n,
	input wire logic [17:0] i_q,
	input wire logic i_q_oe,
	output logic o_k,
	output logic o_k_n,
	output logic o_c,
	output logic o_c_n,
	output logic [3:0] o_addr,
	output logic o_rd_sel_n,
	output logic o_wr_sel_n,
	output logic [1:0] o_byte_sel_n,
	output logic [17:0] o_data
);
	logic [2:0] ph = 3'h3;
	always @(posedge i_clk)
		ph <= ph + 3'h1;
	assign o_k = ~ph[2];
	assign o_k_n = ph[2];
	// The strap stands from before reset, as the choice is fixed after it.
	assign o_c = o_k | i_strap;
	assign o_c_n = o_k_n | i_strap;
	initial
	begin
		o_addr = 4'h0;
		o_rd_sel_n = 1'b1;
		o_wr_sel_n = 1'b1;
		o_byte_sel_n = 2'h3;
		o_data = 18'h00000;
	end
	task automatic at(input [2:0] p);
		do
			@(posedge i_clk);
		while (ph != p);
	endtask
	// Selects settle half a cycle before the K rise; data changes between edges.
	task automatic wr(input [3:0] a, input [71:0] d, input [7:0] m, input hold, input sa);
		integer i;
		at(3);
		o_wr_sel_n <= 1'b0;
		if (sa)
			o_addr <= a;
		at(1);
		o_wr_sel_n <= !hold;
		if (sa)
			o_addr <= a + 4'h5;
		for (i = 0; i < 4; i++)
		begin
			at(i[0] ? 3'h1 : 3'h5);
			o_data <= d[18*i+:18];
			o_byte_sel_n <= m[2*i+:2];
			if (i == 1)
				o_wr_sel_n <= 1'b1;
		end
		at(5);
		o_data <= ~o_data;
		o_byte_sel_n <= 2'h3;
	endtask
	task automatic rd(input [3:0] a, input hold, output [71:0] q, output ok);
		integer i;
		ok = 1'b1;
		at(3);
		o_rd_sel_n <= 1'b0;
		o_addr <= a;
		at(1);
		o_rd_sel_n <= !hold;
		o_addr <= ~a;
		at(1);
		o_rd_sel_n <= 1'b1;
		repeat (i_dll_n ? 7 : 3) @(posedge i_clk);
		for (i = 0; i < 4; i++)
		begin
			@(negedge i_clk);
			q[18*i+:18] = i_q;
			ok &= i_q_oe;
			repeat (4) @(posedge i_clk);
		end
		repeat (9) @(posedge i_clk);
		ok &= !i_q_oe;
	endtask
endmodule
`default_nettype wire

// file: tb/qrbs_sram_tb.sv
// Self-checking bench for the burst SRAM with a shadow copy of its array.
// Assumes the design, the checker and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module qrbs_sram_tb;
	localparam [71:0] pat = 72'h9E3779B97F4A7C15AB;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic strap = 1'b0;
	logic dll_n = 1'b1;
	logic k, k_n, c, c_n, rd_sel_n, wr_sel_n, q_oe, e_pos, e_neg, imp, ok;
	logic k_d = 1'b0;
	logic [3:0] addr;
	logic [1:0] byte_sel_n;
	logic [17:0] data, q, mem [0:15];
	logic [71:0] got;
	integer err_total = 0, check_count = 0, cyc = 0, krise = 0, kat = 0, j;
	qrbs_ctl i_qrbs_ctl (.i_clk(i_clk), .i_strap(strap), .i_dll_n(dll_n), .i_q(q), .i_q_oe(q_oe), .o_k(k),
		.o_k_n(k_n), .o_c(c), .o_c_n(c_n), .o_addr(addr), .o_rd_sel_n(rd_sel_n), .o_wr_sel_n(wr_sel_n),
		.o_byte_sel_n(byte_sel_n), .o_data(data));
	qrbs_sram i_qrbs_sram (.i_clk(i_clk), .i_reset(i_reset), .i_k(k), .i_k_n(k_n), .i_c(c), .i_c_n(c_n),
		.i_addr(addr), .i_read_port_select_n(rd_sel_n), .i_write_port_select_n(wr_sel_n),
		.i_byte_write_select_n(byte_sel_n),
		.i_data(data), .i_dll_disable_n(dll_n), .o_q(q), .o_q_oe(q_oe), .o_echo_timing_pos(e_pos),
		.o_echo_timing_neg(e_neg), .o_impedance_update(imp));
	initial
		forever #50 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		k_d <= k;
		if (k && !k_d && !i_reset)
			krise <= krise + 1;
		if (imp && kat == 0)
			kat <= krise;
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			conclude;
		end
	end
	task automatic cmp(input [71:0] g, input [71:0] e);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input [3:0] a, input [71:0] d, input [7:0] m, input hold);
		integer i;
		i_qrbs_ctl.wr(a, d, m, hold, 1'b1);
		for (i = 0; i < 8; i++)
			if (!m[i])
				mem[(a + i / 2) % 16][9*(i%2)+:9] = d[9*i+:9];
	endtask
	task automatic rd(input [3:0] a, input hold);
		logic [71:0] e;
		integer i;
		i_qrbs_ctl.rd(a, hold, got, ok);
		for (i = 0; i < 4; i++)
			e[18*i+:18] = mem[(a + i) % 16];
		cmp(got, e);
		cmp(ok, 1'b1);
	endtask
	// Sampled after the K fall, when the echoes still show the high half.
	task echo;
		i_qrbs_ctl.at(4);
		@(negedge i_clk);
		cmp({e_pos, e_neg}, 2'h2);
	endtask
	task conclude;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_reset <= 1'b0;
		cmp(q_oe, 1'b0);
		for (j = 0; j < 16; j += 4)
			wr(j[3:0], pat * (j + 1), 8'h00, 1'b0);
		for (j = 0; j < 16; j += 4)
			rd(j[3:0], 1'b0);
		wr(4'hE, ~pat, 8'h93, 1'b0);
		rd(4'hE, 1'b0);
		wr(4'h2, pat << 4, 8'h00, 1'b1);
		rd(4'h7, 1'b0);
		rd(4'h3, 1'b1);
		fork
			wr(4'h5, pat >> 4, 8'h00, 1'b0);
			begin
				repeat (8) @(posedge i_clk);
				rd(4'h5, 1'b0);
			end
		join
		// Both selects stay low for two rises: the read wins the first, the write the second.
		// The write then takes its address from the read's second phase and only words two and three.
		fork
			i_qrbs_ctl.wr(4'h9, pat, 8'h00, 1'b1, 1'b0);
			rd(4'h2, 1'b1);
		join
		mem[13] = pat[36+:18];
		mem[14] = pat[54+:18];
		rd(4'hD, 1'b0);
		dll_n <= 1'b0;
		rd(4'hC, 1'b0);
		dll_n <= 1'b1;
		for (j = 0; j < 9000 && kat == 0; j++)
			@(posedge i_clk);
		cmp(kat, 1024);
		echo;
		i_qrbs_ctl.at(2);
		i_reset <= 1'b1;
		strap <= 1'b1;
		repeat (10) @(posedge i_clk);
		i_reset <= 1'b0;
		wr(4'h0, pat, 8'h00, 1'b0);
		rd(4'h0, 1'b0);
		echo;
		conclude;
	end
endmodule
bind qrbs_sram qrbs_checker i_qrbs_checker (.i_clk(i_clk), .i_reset(i_reset), .i_c(i_c), .i_c_n(i_c_n),
	.i_read_port_select_n(i_read_port_select_n), .o_q(o_q), .o_q_oe(o_q_oe), .o_echo_timing_pos(o_echo_timing_pos),
	.o_echo_timing_neg(o_echo_timing_neg), .o_impedance_update(o_impedance_update));
`default_nettype wire
